/* pkg/fxm_pkg.sv */
// shared constants and types for the fifo expansion block
package fxm_pkg;
	// ----------------------------------------
	// memory geometry
	// ----------------------------------------
	localparam int          DW      = 18;
	localparam int          AW      = 9;
	localparam int          DEPTH   = 512;
	localparam logic [AW:0] LVL_MAX = 10'h200;
	localparam logic [AW:0] LVL_HF  = 10'h101;
	localparam logic [AW-1:0] LAST  = 9'h1ff;
	localparam logic [AW-1:0] ADR0  = 9'h000;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int         BAW       = 4;
	localparam logic [3:0] REG_AE    = 4'h0;
	localparam logic [3:0] REG_AF    = 4'h4;
	localparam logic [3:0] REG_STAT  = 4'h8;
	localparam logic [AW:0] AE_RST   = 10'h03f;
	localparam logic [AW:0] AF_RST   = 10'h03f;
	localparam int         ST_LVL    = 0;
	localparam int         ST_MODE   = 10;
	localparam int         ST_LEG    = 13;
	localparam int         ST_WTOK   = 14;
	localparam int         ST_RTOK   = 15;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
	// ----------------------------------------
	// operating configuration
	// ----------------------------------------
	typedef enum logic [2:0] {
		FXM_ALONE  = 3'b001,
		FXM_MASTER = 3'b010,
		FXM_SLAVE  = 3'b100
	} fxm_mode_t;

	function automatic logic [AW:0] fxm_level(input logic [AW:0] w, input logic [AW:0] r);
		fxm_level = w - r;
	endfunction
endpackage

/* hdl/fxm_mode.sv */
// captures the operating configuration around reset
`timescale 1ns/1ps
`default_nettype none
module fxm_mode (
	input  wire logic        ref_clk,  // clock
	input  wire logic        nrst,     // async reset, low
	input  wire logic        wx_in,    // write chain input level
	input  wire logic        rx_in,    // read chain input level
	input  wire logic        fl_in,    // first load / replay level
	input  wire logic        sel_in,   // operating mode select
	output fxm_pkg::fxm_mode_t mode,   // latched configuration
	output logic             legacy    // latched legacy mode
);
	logic first;

	// pins cannot enter an async-reset flop, so sample at the first edge after release
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			first <= 1'b1;
		end else begin
			first <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			mode   <= fxm_pkg::FXM_ALONE;
			legacy <= 1'b1;
		end else if (first) begin
			legacy <= sel_in;
			if (!wx_in && !rx_in) begin
				mode <= fxm_pkg::FXM_ALONE;
			end else if (!fl_in) begin
				mode <= fxm_pkg::FXM_MASTER;
			end else begin
				mode <= fxm_pkg::FXM_SLAVE;
			end
		end
	end
endmodule
`default_nettype wire

/* hdl/fxm_mem.sv */
// storage array with one write and one registered read port
`timescale 1ns/1ps
`default_nettype none
module fxm_mem (
	input  wire logic                   ref_clk, // clock
	input  wire logic                   we,      // write strobe
	input  wire logic [fxm_pkg::AW-1:0] wa,      // write address
	input  wire logic [fxm_pkg::DW-1:0] wd,      // write data
	input  wire logic                   re,      // read strobe
	input  wire logic [fxm_pkg::AW-1:0] ra,      // read address
	output logic      [fxm_pkg::DW-1:0] rd       // read data, registered
);
	logic [fxm_pkg::DW-1:0] arr [fxm_pkg::DEPTH];

	always_ff @(posedge ref_clk) begin
		if (we) begin
			arr[wa] <= wd;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (re) begin
			rd <= arr[ra];
		end
	end
endmodule
`default_nettype wire

/* hdl/fxm_top.sv */
// fifo core with standalone, paralleled and token-ring expansion
// How it works
// - standalone: a rising first-load pin restarts reading from location zero.
// - both chain outputs are high while reset is held.
// - ring members never replay.
// - clocks and enables are shared; tokens pick the active device.
// - only the write-token holder stores a presented word.
// - only the read-token holder reads and drives data outputs.
// - each word is stored and read by one device only.
// - in a ring the half-level flag is replaced by the write token output.
// - standalone flags depend only on write, read and replay activity, and the almost flags also on the offset registers.
// - ring: one low pulse on read chain output after last location read.
// - read token arrival activates reading next edge; sender floats outputs.
// - configuration is caught from chain inputs and first-load pin at reset.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module fxm_top (
	input  wire logic                   ref_clk,    // 25 MHz clock
	input  wire logic                   nrst,       // async reset, low
	input  wire logic                   write_en_n, // write enable, low
	input  wire logic [fxm_pkg::DW-1:0] data_in,    // write data
	input  wire logic                   read_en_n,  // read enable, low
	input  wire logic                   out_en_n,   // output enable, low
	output logic      [fxm_pkg::DW-1:0] data_out,   // read data
	output logic                        data_oe,    // data output enable
	input  wire logic                   write_chain_in_or_alt_write_enable, // token in / enable
	input  wire logic                   read_chain_in_or_alt_read_enable,   // token in / enable
	input  wire logic                   first_load_or_replay,               // strap / replay
	input  wire logic                   operating_mode_select,              // high: legacy
	output logic                        write_chain_out_or_half_level,      // token / half flag
	output logic                        read_chain_out_or_delayed_empty,    // token / empty copy
	output logic                        full_flag_n,         // full, low
	output logic                        empty_flag_n,        // empty, low
	output logic                        almost_full_flag_n,  // almost full, low
	output logic                        almost_empty_flag_n, // almost empty, low
	input  wire logic [fxm_pkg::BAW-1:0] reg_addr,  // register byte address
	input  wire logic [31:0]            reg_wdata,  // register write data
	input  wire logic                   reg_wr,     // register write strobe
	input  wire logic                   reg_rd,     // register read strobe
	output logic      [31:0]            reg_rdata   // read data, cycle after strobe
);
	localparam int AW = fxm_pkg::AW;

	fxm_pkg::fxm_mode_t mode;
	logic          legacy;
	logic          ring;
	logic [AW:0]   wptr;
	logic [AW:0]   rptr;
	logic [AW:0]   next_wptr;
	logic [AW:0]   next_rptr;
	logic [AW:0]   lvl;
	logic [AW:0]   next_lvl;
	logic [AW:0]   ae_ofs;
	logic [AW:0]   af_ofs;
	logic          wtok;
	logic          rtok;
	logic          wr_go;
	logic          rd_go;
	logic          replay_go;
	logic          replay_d;
	logic          empty_q;
	logic [fxm_pkg::DW-1:0] mem_q;
	logic          cfg_seen;
	logic          slave_strap;

	fxm_mode u_mode (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.wx_in   (write_chain_in_or_alt_write_enable),
		.rx_in   (read_chain_in_or_alt_read_enable),
		.fl_in   (first_load_or_replay),
		.sel_in  (operating_mode_select),
		.mode    (mode),
		.legacy  (legacy)
	);

	assign ring = legacy && (mode != fxm_pkg::FXM_ALONE);
	assign lvl  = fxm_pkg::fxm_level(wptr, rptr);
	// slave decode the mode latch applies, gated by the legacy select, seen while it is being taken
	assign slave_strap = operating_mode_select && first_load_or_replay
		&& (write_chain_in_or_alt_write_enable || read_chain_in_or_alt_read_enable);

	// ----------------------------------------
	// write and read qualification
	// ----------------------------------------
	always_comb begin
		// enhanced mode turns the chain inputs into extra high-active enables
		wr_go = !write_en_n && (lvl != fxm_pkg::LVL_MAX) && wtok
			&& (legacy || write_chain_in_or_alt_write_enable);
		rd_go = !read_en_n && (lvl != '0) && rtok
			&& (legacy || read_chain_in_or_alt_read_enable);
		// mode is only valid after the strap edge; a high strap is no replay
		replay_go = cfg_seen && (mode == fxm_pkg::FXM_ALONE) && first_load_or_replay
			&& !replay_d;
	end

	always_comb begin
		next_wptr = wr_go ? wptr + 1'b1 : wptr;
		next_rptr = rd_go ? rptr + 1'b1 : rptr;
		if (replay_go) begin
			next_rptr = {wptr[AW], fxm_pkg::ADR0};
		end
		next_lvl = fxm_pkg::fxm_level(next_wptr, next_rptr);
	end

	fxm_mem u_mem (
		.ref_clk (ref_clk),
		.we      (wr_go),
		.wa      (wptr[AW-1:0]),
		.wd      (data_in),
		.re      (rd_go),
		.ra      (rptr[AW-1:0]),
		.rd      (mem_q)
	);
	assign data_out = mem_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wptr     <= '0;
			rptr     <= '0;
			replay_d <= 1'b0;
		end else begin
			wptr     <= next_wptr;
			rptr     <= next_rptr;
			replay_d <= first_load_or_replay;
		end
	end

	// ----------------------------------------
	// tokens: arrival sets, passing clears; arrival wins
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wtok <= 1'b1;
			rtok <= 1'b1;
		end else if (!cfg_seen) begin
			// straps are latched at this edge; a slave must not start as a second holder
			wtok <= !slave_strap;
			rtok <= !slave_strap;
		end else if (!ring) begin
			wtok <= 1'b1;
			rtok <= 1'b1;
		end else begin
			if (wr_go && wptr[AW-1:0] == fxm_pkg::LAST) begin
				wtok <= 1'b0;
			end
			if (!write_chain_in_or_alt_write_enable) begin
				wtok <= 1'b1;
			end
			if (rd_go && rptr[AW-1:0] == fxm_pkg::LAST) begin
				rtok <= 1'b0;
			end
			if (!read_chain_in_or_alt_read_enable) begin
				rtok <= 1'b1;
			end
		end
	end

	// token holder only; a slave starts without either token
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			data_oe <= 1'b0;
		end else if (!cfg_seen) begin
			data_oe <= !out_en_n && !slave_strap;
		end else begin
			data_oe <= !out_en_n && (!ring || next_rtok_hold());
		end
	end

	function automatic logic next_rtok_hold();
		next_rtok_hold = (!read_chain_in_or_alt_read_enable)
			|| (rtok && !(rd_go && rptr[AW-1:0] == fxm_pkg::LAST));
	endfunction

	// slave drops the initial tokens once its configuration is known
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_seen <= 1'b0;
		end else begin
			cfg_seen <= 1'b1;
		end
	end

	// ----------------------------------------
	// chain outputs and flags
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			write_chain_out_or_half_level   <= 1'b1;
			read_chain_out_or_delayed_empty <= 1'b1;
			empty_q                         <= 1'b0;
		end else begin
			empty_q <= (next_lvl == '0);
			if (ring) begin
				write_chain_out_or_half_level <= !(wr_go
					&& wptr[AW-1:0] == fxm_pkg::LAST);
				read_chain_out_or_delayed_empty <= !(rd_go
					&& rptr[AW-1:0] == fxm_pkg::LAST);
			end else begin
				write_chain_out_or_half_level   <= !(next_lvl >= fxm_pkg::LVL_HF);
				read_chain_out_or_delayed_empty <= legacy ? 1'b1 : !empty_q;
			end
		end
	end

	// flags follow only the pointers and the offset registers, so paralleled parts agree
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			full_flag_n         <= 1'b1;
			empty_flag_n        <= 1'b0;
			almost_full_flag_n  <= 1'b1;
			almost_empty_flag_n <= 1'b0;
		end else begin
			full_flag_n         <= !(next_lvl == fxm_pkg::LVL_MAX);
			empty_flag_n        <= !(next_lvl == '0);
			almost_full_flag_n  <= !(next_lvl >= fxm_pkg::LVL_MAX - af_ofs);
			almost_empty_flag_n <= !(next_lvl <= ae_ofs);
		end
	end

	// ----------------------------------------
	// register port
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ae_ofs <= fxm_pkg::AE_RST;
			af_ofs <= fxm_pkg::AF_RST;
		end else if (reg_wr) begin
			if (reg_addr == fxm_pkg::REG_AE) begin
				ae_ofs <= reg_wdata[AW:0];
			end
			if (reg_addr == fxm_pkg::REG_AF) begin
				af_ofs <= reg_wdata[AW:0];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= fxm_pkg::RD_ZERO;
		end else begin
			reg_rdata <= fxm_pkg::RD_ZERO;
			if (reg_rd) begin
				case (reg_addr)
					fxm_pkg::REG_AE: reg_rdata[AW:0] <= ae_ofs;
					fxm_pkg::REG_AF: reg_rdata[AW:0] <= af_ofs;
					fxm_pkg::REG_STAT: begin
						reg_rdata[fxm_pkg::ST_LVL +: AW+1] <= lvl;
						reg_rdata[fxm_pkg::ST_MODE +: 3]   <= mode;
						reg_rdata[fxm_pkg::ST_LEG]         <= legacy;
						reg_rdata[fxm_pkg::ST_WTOK]        <= wtok;
						reg_rdata[fxm_pkg::ST_RTOK]        <= rtok;
					end
					default: reg_rdata <= fxm_pkg::RD_ZERO;
				endcase
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_rst_high;
		@(posedge ref_clk) disable iff (1'b0)
		!nrst |-> write_chain_out_or_half_level && read_chain_out_or_delayed_empty;
	endproperty
	a_rst_high: assert property (p_rst_high) else $error("chain out low in reset");

	property p_wr_token;
		!wtok |=> $stable(wptr);
	endproperty
	a_wr_token: assert property (p_wr_token) else $error("write without token");

	property p_oe_token;
		ring && data_oe |-> rtok;
	endproperty
	a_oe_token: assert property (p_oe_token) else $error("drive without token");

	property p_rxo_pulse;
		ring && rd_go && rptr[AW-1:0] == fxm_pkg::LAST && read_chain_in_or_alt_read_enable
		|=> !read_chain_out_or_delayed_empty && !rtok ##1 read_chain_out_or_delayed_empty;
	endproperty
	a_rxo_pulse: assert property (p_rxo_pulse) else $error("read token pulse");

	property p_rxo_idle;
		ring && !read_chain_out_or_delayed_empty |-> $past(rd_go) && $past(rptr[AW-1:0]) == fxm_pkg::LAST;
	endproperty
	a_rxo_idle: assert property (p_rxo_idle) else $error("stray read token");

	property p_wxo_pulse;
		ring && !write_chain_out_or_half_level |-> $past(wr_go) && $past(wptr[AW-1:0]) == fxm_pkg::LAST;
	endproperty
	a_wxo_pulse: assert property (p_wxo_pulse) else $error("stray write token");

	property p_rtok_arrive;
		ring && !read_chain_in_or_alt_read_enable |=> rtok;
	endproperty
	a_rtok_arrive: assert property (p_rtok_arrive) else $error("token not taken");

	property p_no_replay;
		mode != fxm_pkg::FXM_ALONE |-> !replay_go;
	endproperty
	a_no_replay: assert property (p_no_replay) else $error("replay in ring");

	property p_replay;
		replay_go |=> rptr[AW-1:0] == fxm_pkg::ADR0 && rptr[AW] == $past(wptr[AW]);
	endproperty
	a_replay: assert property (p_replay) else $error("replay did not rewind");

	property p_full_flag;
		##1 full_flag_n == (lvl != fxm_pkg::LVL_MAX);
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("full flag mismatch");

	property p_mode_hold;
		cfg_seen && $past(cfg_seen) |-> $stable(mode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
endmodule
`default_nettype wire

/* verif/fxm_ring_peer.sv */
// rest of a token ring: hands tokens back to the device after a delay
`timescale 1ns/1ps
`default_nettype none
module fxm_ring_peer #(
	parameter int LAT = 40 // cycles the other ring members keep a token
) (
	input  wire logic ref_clk, // clock
	input  wire logic ring,    // high: token ring, low: standalone straps
	input  wire logic wtok_o,  // write token from the device
	input  wire logic rtok_o,  // read token from the device
	output logic      wtok_i,  // write token back to the device
	output logic      rtok_i   // read token back to the device
);
	int wcnt = 0;
	int rcnt = 0;
	// ----------------------------------------
	// token return
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!wtok_o) begin
			wcnt <= LAT;
		end else if (wcnt > 0) begin
			wcnt <= wcnt - 1;
		end
		if (!rtok_o) begin
			rcnt <= LAT;
		end else if (rcnt > 0) begin
			rcnt <= rcnt - 1;
		end
	end
	// idle high in a ring, so the straps read high during reset
	assign wtok_i = ring ? (wcnt != 1) : 1'b0;
	assign rtok_i = ring ? (rcnt != 1) : 1'b0;
endmodule
`default_nettype wire

/* verif/tb_top.sv */
// self-checking bench for the fifo expansion block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                    ref_clk    = 1'b0;
	logic                    nrst       = 1'b1;
	logic                    write_en_n = 1'b1;
	logic [fxm_pkg::DW-1:0]  data_in    = '0;
	logic                    read_en_n  = 1'b1;
	logic                    fl         = 1'b0;
	logic                    ring       = 1'b0;
	logic                    sel        = 1'b1;
	logic [fxm_pkg::BAW-1:0] reg_addr   = '0;
	logic [31:0]             reg_wdata  = '0;
	logic                    reg_wr     = 1'b0;
	logic                    reg_rd     = 1'b0;
	logic [31:0]             got;
	wire logic [fxm_pkg::DW-1:0] data_out;
	wire logic [31:0]        reg_rdata;
	wire logic               data_oe;
	wire logic               wx_in;
	wire logic               rx_in;
	wire logic               wx_out;
	wire logic               rx_out;
	wire logic               full_n;
	wire logic               empty_n;
	wire logic               af_n;
	wire logic               ae_n;
	int                      n_mismatch = 0;
	int                      n_tests    = 0;
	int                      n_cyc      = 0;
	int                      n_wlow     = 0;
	int                      n_rlow     = 0;

	fxm_top fxm_top_i (.ref_clk(ref_clk), .nrst(nrst), .write_en_n(write_en_n),
		.data_in(data_in), .read_en_n(read_en_n), .out_en_n(1'b0), .data_out(data_out),
		.data_oe(data_oe), .write_chain_in_or_alt_write_enable(wx_in),
		.read_chain_in_or_alt_read_enable(rx_in), .first_load_or_replay(fl),
		.operating_mode_select(sel), .write_chain_out_or_half_level(wx_out),
		.read_chain_out_or_delayed_empty(rx_out), .full_flag_n(full_n),
		.empty_flag_n(empty_n), .almost_full_flag_n(af_n), .almost_empty_flag_n(ae_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));
	fxm_ring_peer fxm_ring_peer_i (.ref_clk(ref_clk), .ring(ring), .wtok_o(wx_out),
		.rtok_o(rx_out), .wtok_i(wx_in), .rtok_i(rx_in));

	// ----------------------------------------
	// clock, token watch, hang limit
	// ----------------------------------------
	initial begin
		forever begin
			#20;
			ref_clk = ~ref_clk;
		end
	end
	always @(posedge ref_clk) begin
		n_cyc++;
		if (nrst && !wx_out) n_wlow++;
		if (nrst && !rx_out) n_rlow++;
		if (n_cyc == 20000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [17:0] word(input int i);
		return 18'(i) ^ 18'h2_a5a5;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic chk_stat(input int lsb, input int w, input logic [31:0] exp);
		rd_reg(fxm_pkg::REG_STAT, got);
		chk((got >> lsb) & ((32'h0000_0001 << w) - 1), exp);
	endtask
	task automatic push(input int s, input int n);
		for (int i = s; i < s + n; i++) begin
			@(posedge ref_clk);
			write_en_n <= 1'b0;
			data_in <= word(i);
		end
		@(posedge ref_clk);
		write_en_n <= 1'b1;
		#1;
	endtask
	task automatic pop(input logic [17:0] exp);
		@(posedge ref_clk);
		read_en_n <= 1'b0;
		@(posedge ref_clk);
		read_en_n <= 1'b1;
		#1;
		chk({14'h0, data_out}, {14'h0, exp});
	endtask
	task automatic pulse_fl();
		@(posedge ref_clk);
		fl <= 1'b1;
		@(posedge ref_clk);
		fl <= 1'b0;
	endtask
	task automatic do_reset(input logic r, input logic f, input logic s);
		@(posedge ref_clk);
		nrst <= 1'b0;
		ring <= r;
		fl <= f;
		sel <= s;
		@(posedge ref_clk);
		#1;
		chk({30'h0, wx_out, rx_out}, 32'h0000_0003);
		@(posedge ref_clk);
		nrst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		n_wlow = 0;
		n_rlow = 0;
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		do_reset(1'b0, 1'b0, 1'b1);
		chk_stat(fxm_pkg::ST_MODE, 3, 32'h0000_0001);
		wr_reg(fxm_pkg::REG_AE, 32'h0000_0005);
		rd_reg(fxm_pkg::REG_AE, got);
		chk(got, 32'h0000_0005);
		rd_reg(4'hc, got);
		chk(got, fxm_pkg::RD_ZERO);
		push(0, 3);
		chk({31'h0, empty_n}, 32'h0000_0001);
		chk({29'h0, wx_out, af_n, ae_n}, 32'h0000_0006);
		pop(word(0));
		pop(word(1));
		pulse_fl();
		pop(word(0));
		// ring master: both tokens held after reset
		do_reset(1'b1, 1'b0, 1'b1);
		chk_stat(fxm_pkg::ST_MODE, 3, 32'h0000_0002);
		chk_stat(fxm_pkg::ST_WTOK, 2, 32'h0000_0003);
		push(0, 512);
		chk({31'h0, full_n}, 32'h0000_0000);
		chk({31'h0, af_n}, 32'h0000_0000);
		@(posedge ref_clk);
		#1;
		chk(n_wlow, 1);
		chk_stat(fxm_pkg::ST_WTOK, 1, 32'h0000_0000);
		pop(word(0));
		pulse_fl();
		pop(word(1));
		push(512, 1);
		chk_stat(fxm_pkg::ST_LVL, 10, 32'd510);
		repeat (40) @(posedge ref_clk);
		push(513, 1);
		chk_stat(fxm_pkg::ST_LVL, 10, 32'd511);
		for (int i = 2; i < 512; i++) pop(word(i));
		@(posedge ref_clk);
		#1;
		chk(n_rlow, 1);
		chk({31'h0, data_oe}, 32'h0000_0000);
		pop(word(511));
		repeat (40) @(posedge ref_clk);
		#1;
		chk({31'h0, data_oe}, 32'h0000_0001);
		pop(word(513));
		// enhanced straps: no ring, chain inputs act as enables
		do_reset(1'b1, 1'b0, 1'b0);
		chk_stat(fxm_pkg::ST_MODE, 4, 32'h0000_0002);
		push(0, 1);
		chk({30'h0, empty_n, rx_out}, 32'h0000_0002);
		@(posedge ref_clk);
		#1;
		chk({30'h0, empty_n, rx_out}, 32'h0000_0003);
		do_reset(1'b1, 1'b1, 1'b1);
		chk_stat(fxm_pkg::ST_MODE, 3, 32'h0000_0004);
		chk_stat(fxm_pkg::ST_WTOK, 2, 32'h0000_0000);
		tally_and_finish();
	end
endmodule
`default_nettype wire
